// ==== cfi_trap_state_control.sv ====
// Expected landing-pad state, its trap save/restore, and CFI exception checks
`timescale 1ns/1ps
module cfi_trap_state_control #(
   parameter bit HAS_SMODE = 1'b1,
   parameter bit HAS_RESUMABLE_NMI = 1'b1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [1:0] cur_prv,
   input wire logic cur_virt,
   input wire logic msec_mlpe,
   input wire logic menv_lpe,
   input wire logic henv_lpe,
   input wire logic senv_lpe,
   input wire logic menv_sse,
   input wire logic henv_sse,
   input wire logic senv_sse,
   input wire logic ind_jump_retire,
   input wire logic instr_valid,
   input wire logic instr_is_pad,
   input wire logic fetch_access_fault,
   input wire logic illegal_instr,
   input wire logic ssp_csr_access,
   input wire logic ss_instr_valid,
   input wire logic trap_take,
   input wire cfi_pkg::cfi_tgt_t trap_tgt,
   input wire logic mret_exec,
   input wire logic sret_exec,
   input wire logic [1:0] ret_prv,
   input wire logic ret_virt,
   input wire logic dbg_enter,
   input wire logic dbg_resume,
   input wire logic [1:0] dbg_prv,
   input wire logic dbg_virt,
   input wire logic nmi_take,
   input wire logic nmi_return,
   input wire logic [1:0] nmi_prv,
   input wire logic nmi_virt,
   input wire logic mst_wr_en,
   input wire logic mst_wr_mpad,
   input wire logic mst_wr_spad,
   input wire logic sst_wr_en,
   input wire logic sst_wr_spad,
   input wire logic vsst_wr_en,
   input wire logic vsst_wr_spad,
   input wire logic dcsr_wr_en,
   input wire logic dcsr_wr_pad,
   input wire logic nmist_wr_en,
   input wire logic nmist_wr_pad,
   output logic expected_landing_pad_state_ff,
   output logic machine_prev_pad_state_ff,
   output logic super_prev_pad_state_ff,
   output logic vs_super_prev_pad_state_ff,
   output logic dbg_prev_pad_state_ff,
   output logic [cfi_pkg::CFI_NMIST_W-1:0] nmi_status_ff,
   output logic mode_pad_check_enable_ff,
   output logic mode_shadow_stack_enable_ff,
   output logic ss_as_mop_ff,
   output logic ssp_access_ok_ff,
   output logic exc_valid_ff,
   output cfi_pkg::cfi_exc_t exc_kind_ff,
   output logic [cfi_pkg::CFI_TVAL_W-1:0] exc_tval_ff
);
   import cfi_pkg::*;

   logic lpe_cur;
   logic sse_cur;
   logic ssp_illegal;
   logic ssp_virt;
   logic lpe_ret;
   logic lpe_dbg;
   logic lpe_nmi;
   logic nmi_take_ok;
   logic nmi_ret_ok;
   logic lp_fault;
   logic entry_evt;
   logic nmi_pad;
   cfi_exc_t nxt_exc_kind;

   cfi_mode_enable #(.HAS_SMODE(HAS_SMODE)) u_cur_en (
      .prv(cur_prv),
      .virt(cur_virt),
      .msec_mlpe(msec_mlpe),
      .menv_lpe(menv_lpe),
      .henv_lpe(henv_lpe),
      .senv_lpe(senv_lpe),
      .menv_sse(menv_sse),
      .henv_sse(henv_sse),
      .senv_sse(senv_sse),
      .lpe(lpe_cur),
      .shadow_stack_enable_field(sse_cur)
   );

   cfi_ssp_gate u_ssp_gate (
      .prv(cur_prv),
      .virt(cur_virt),
      .menv_sse(menv_sse),
      .henv_sse(henv_sse),
      .senv_sse(senv_sse),
      .illegal(ssp_illegal),
      .virt_instr(ssp_virt)
   );

   // Enable of the privilege each return is headed for
   assign lpe_ret = cfi_lpe_of(ret_prv, ret_virt, HAS_SMODE, msec_mlpe, menv_lpe,
                               henv_lpe, senv_lpe);
   assign lpe_dbg = cfi_lpe_of(dbg_prv, dbg_virt, HAS_SMODE, msec_mlpe, menv_lpe,
                               henv_lpe, senv_lpe);
   assign lpe_nmi = cfi_lpe_of(nmi_prv, nmi_virt, HAS_SMODE, msec_mlpe, menv_lpe,
                               henv_lpe, senv_lpe);
   // Without resumable NMI the NMI strobes are ignored
   assign nmi_take_ok = HAS_RESUMABLE_NMI && nmi_take;
   assign nmi_ret_ok = HAS_RESUMABLE_NMI && nmi_return;
   assign entry_evt = dbg_enter || nmi_take_ok || trap_take;
   assign lp_fault = instr_valid && expected_landing_pad_state_ff == CFI_PAD_REQUIRED
                     && !instr_is_pad;
   assign nmi_pad = nmi_status_ff[CFI_NMI_PAD_BIT];

   // Entries beat returns; the core never issues both, this only fixes the order
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         expected_landing_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (entry_evt) begin
         expected_landing_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (dbg_resume) begin
         expected_landing_pad_state_ff <= lpe_dbg ? dbg_prev_pad_state_ff
                                                  : CFI_PAD_NOT_REQUIRED;
      end else if (nmi_ret_ok) begin
         expected_landing_pad_state_ff <= lpe_nmi ? nmi_pad : CFI_PAD_NOT_REQUIRED;
      end else if (mret_exec) begin
         expected_landing_pad_state_ff <= lpe_ret ? machine_prev_pad_state_ff
                                                  : CFI_PAD_NOT_REQUIRED;
      end else if (sret_exec) begin
         if (!lpe_ret) begin
            expected_landing_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
         end else if (cur_virt) begin
            expected_landing_pad_state_ff <= vs_super_prev_pad_state_ff;
         end else begin
            expected_landing_pad_state_ff <= super_prev_pad_state_ff;
         end
      end else if (instr_valid && instr_is_pad) begin
         expected_landing_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (ind_jump_retire && lpe_cur) begin
         expected_landing_pad_state_ff <= CFI_PAD_REQUIRED;
      end
   end

   // Hardware saves win over a software write in the same cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         machine_prev_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (trap_take && !dbg_enter && !nmi_take_ok && trap_tgt == CFI_TGT_M) begin
         machine_prev_pad_state_ff <= expected_landing_pad_state_ff;
      end else if (mret_exec && !entry_evt) begin
         machine_prev_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (mst_wr_en) begin
         machine_prev_pad_state_ff <= mst_wr_mpad;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         super_prev_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (trap_take && !dbg_enter && !nmi_take_ok && trap_tgt == CFI_TGT_HS) begin
         super_prev_pad_state_ff <= expected_landing_pad_state_ff;
      end else if (sret_exec && !cur_virt && !entry_evt) begin
         super_prev_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (sst_wr_en) begin
         super_prev_pad_state_ff <= sst_wr_spad;
      end else if (mst_wr_en) begin
         super_prev_pad_state_ff <= mst_wr_spad;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         vs_super_prev_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (trap_take && !dbg_enter && !nmi_take_ok && trap_tgt == CFI_TGT_VS) begin
         vs_super_prev_pad_state_ff <= expected_landing_pad_state_ff;
      end else if (sret_exec && cur_virt && !entry_evt) begin
         vs_super_prev_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (vsst_wr_en) begin
         vs_super_prev_pad_state_ff <= vsst_wr_spad;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dbg_prev_pad_state_ff <= CFI_PAD_NOT_REQUIRED;
      end else if (dbg_enter) begin
         dbg_prev_pad_state_ff <= expected_landing_pad_state_ff;
      end else if (dcsr_wr_en) begin
         dbg_prev_pad_state_ff <= dcsr_wr_pad;
      end
   end

   // Only the pad field lives here; other NMI status bits belong to the CSR file
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         nmi_status_ff <= CFI_NMIST_RESET;
      end else if (nmi_take_ok && !dbg_enter) begin
         nmi_status_ff[CFI_NMI_PAD_BIT] <= expected_landing_pad_state_ff;
      end else if (HAS_RESUMABLE_NMI && nmist_wr_en) begin
         nmi_status_ff[CFI_NMI_PAD_BIT] <= nmist_wr_pad;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mode_pad_check_enable_ff <= 1'b0;
         mode_shadow_stack_enable_ff <= 1'b0;
         ss_as_mop_ff <= 1'b0;
         ssp_access_ok_ff <= 1'b0;
      end else begin
         mode_pad_check_enable_ff <= lpe_cur;
         mode_shadow_stack_enable_ff <= sse_cur;
         ss_as_mop_ff <= ss_instr_valid && !sse_cur;
         ssp_access_ok_ff <= ssp_csr_access && !ssp_illegal && !ssp_virt;
      end
   end

   always_comb begin
      nxt_exc_kind = CFI_EXC_NONE;
      if (fetch_access_fault) begin
         nxt_exc_kind = CFI_EXC_FETCH_ACCESS;
      end else if (lp_fault) begin
         nxt_exc_kind = CFI_EXC_SW_CHECK;
      end else if (illegal_instr || (ssp_csr_access && ssp_illegal)) begin
         nxt_exc_kind = CFI_EXC_ILLEGAL;
      end else if (ssp_csr_access && ssp_virt) begin
         nxt_exc_kind = CFI_EXC_VIRT_INSTR;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         exc_valid_ff <= 1'b0;
         exc_kind_ff <= CFI_EXC_NONE;
         exc_tval_ff <= CFI_TVAL_NONE;
      end else begin
         exc_valid_ff <= nxt_exc_kind != CFI_EXC_NONE;
         exc_kind_ff <= nxt_exc_kind;
         exc_tval_ff <= (nxt_exc_kind == CFI_EXC_SW_CHECK) ? CFI_TVAL_LP_FAULT
                                                            : CFI_TVAL_NONE;
      end
   end

   a_trap_clears_pad: assert property (@(posedge clk_sys) disable iff (!nrst)
      trap_take |=> expected_landing_pad_state_ff == CFI_PAD_NOT_REQUIRED)
      else $error("pad state not cleared after trap");

   a_mtrap_saves_pad: assert property (@(posedge clk_sys) disable iff (!nrst)
      trap_take && !dbg_enter && !nmi_take_ok && trap_tgt == CFI_TGT_M
      |=> machine_prev_pad_state_ff == $past(expected_landing_pad_state_ff))
      else $error("machine saved pad bit wrong after trap");

   a_vstrap_saves_pad: assert property (@(posedge clk_sys) disable iff (!nrst)
      trap_take && !dbg_enter && !nmi_take_ok && trap_tgt == CFI_TGT_VS
      && !sst_wr_en && !mst_wr_en
      |=> vs_super_prev_pad_state_ff == $past(expected_landing_pad_state_ff)
          && super_prev_pad_state_ff == $past(super_prev_pad_state_ff))
      else $error("guest supervisor pad bit wrong after trap");

   a_mret_restores_pad: assert property (@(posedge clk_sys) disable iff (!nrst)
      mret_exec && !entry_evt && !dbg_resume && !nmi_ret_ok
      |=> expected_landing_pad_state_ff == ($past(lpe_ret) & $past(machine_prev_pad_state_ff))
          && machine_prev_pad_state_ff == CFI_PAD_NOT_REQUIRED)
      else $error("machine return restore wrong");

   a_sst_view_write: assert property (@(posedge clk_sys) disable iff (!nrst)
      sst_wr_en && !trap_take && !sret_exec
      |=> super_prev_pad_state_ff == $past(sst_wr_spad))
      else $error("supervisor view write lost");

   a_dbg_save_restore: assert property (@(posedge clk_sys) disable iff (!nrst)
      dbg_enter |=> dbg_prev_pad_state_ff == $past(expected_landing_pad_state_ff)
                    && expected_landing_pad_state_ff == CFI_PAD_NOT_REQUIRED)
      else $error("debug entry pad handling wrong");

   a_dbg_resume_pad: assert property (@(posedge clk_sys) disable iff (!nrst)
      dbg_resume && !entry_evt
      |=> expected_landing_pad_state_ff == ($past(lpe_dbg) & $past(dbg_prev_pad_state_ff)))
      else $error("debug resume pad wrong");

   a_nmi_save_pad: assert property (@(posedge clk_sys) disable iff (!nrst)
      nmi_take_ok && !dbg_enter ##1 !nmi_ret_ok && !nmist_wr_en
      |=> nmi_status_ff[CFI_NMI_PAD_BIT] == $past(expected_landing_pad_state_ff, 2))
      else $error("nmi saved pad bit wrong");

   a_nmi_return_pad: assert property (@(posedge clk_sys) disable iff (!nrst)
      nmi_ret_ok && !entry_evt && !dbg_resume
      |=> expected_landing_pad_state_ff == ($past(lpe_nmi) & $past(nmi_pad)))
      else $error("nmi return pad wrong");

   a_lp_fault_exc: assert property (@(posedge clk_sys) disable iff (!nrst)
      lp_fault && !fetch_access_fault
      |=> exc_valid_ff && exc_kind_ff == CFI_EXC_SW_CHECK
          && exc_tval_ff == CFI_TVAL_LP_FAULT)
      else $error("landing pad fault not reported with code 2");

   a_exc_priority: assert property (@(posedge clk_sys) disable iff (!nrst)
      (fetch_access_fault |=> exc_kind_ff == CFI_EXC_FETCH_ACCESS)
      and (lp_fault && illegal_instr && !fetch_access_fault
           |=> exc_kind_ff == CFI_EXC_SW_CHECK))
      else $error("exception priority wrong");

   a_ssp_machine_env: assert property (@(posedge clk_sys) disable iff (!nrst)
      ssp_csr_access && cur_prv != CFI_PRV_M && !menv_sse && !fetch_access_fault && !lp_fault
      |=> exc_kind_ff == CFI_EXC_ILLEGAL && !ssp_access_ok_ff)
      else $error("pointer access below machine not refused");

   a_ssp_virt_user: assert property (@(posedge clk_sys) disable iff (!nrst)
      ssp_csr_access && cur_prv == CFI_PRV_U && cur_virt && menv_sse && !henv_sse
      && !fetch_access_fault && !lp_fault && !illegal_instr
      |=> exc_kind_ff == CFI_EXC_VIRT_INSTR)
      else $error("virtual user pointer access not refused");

   a_sse_machine_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
      cur_prv == CFI_PRV_M |=> !mode_shadow_stack_enable_ff)
      else $error("machine shadow-stack enable not zero");

   a_ss_fallback_mop: assert property (@(posedge clk_sys) disable iff (!nrst)
      ss_instr_valid |=> ss_as_mop_ff == !mode_shadow_stack_enable_ff)
      else $error("shadow-stack fallback wrong");
endmodule

// ==== cfi_pkg.sv ====
// Shared constants, types and the pad-enable decode function for the CFI trap state block
package cfi_pkg;
   localparam logic [1:0] CFI_PRV_U = 2'h0;
   localparam logic [1:0] CFI_PRV_S = 2'h1;
   localparam logic [1:0] CFI_PRV_M = 2'h3;
   localparam logic CFI_PAD_NOT_REQUIRED = 1'h0;
   localparam logic CFI_PAD_REQUIRED = 1'h1;
   localparam int CFI_TVAL_W = 32;
   localparam logic [CFI_TVAL_W-1:0] CFI_TVAL_LP_FAULT = 32'h0000_0002;
   localparam logic [CFI_TVAL_W-1:0] CFI_TVAL_NONE = 32'h0000_0000;
   localparam int CFI_NMIST_W = 16;
   localparam int CFI_NMI_PAD_BIT = 9;
   localparam logic [CFI_NMIST_W-1:0] CFI_NMIST_RESET = 16'h0000;

   typedef enum logic [1:0] {CFI_TGT_M, CFI_TGT_HS, CFI_TGT_VS} cfi_tgt_t;
   typedef enum logic [2:0] {
      CFI_EXC_NONE, CFI_EXC_FETCH_ACCESS, CFI_EXC_SW_CHECK, CFI_EXC_ILLEGAL,
      CFI_EXC_VIRT_INSTR
   } cfi_exc_t;

   // Pad-check enable of one privilege; used for the current mode and every return path
   function automatic logic cfi_lpe_of(input logic [1:0] prv, input logic virt,
                                       input logic has_s, input logic mlpe,
                                       input logic menv, input logic henv,
                                       input logic senv);
      logic en;
      en = 1'b0;
      if (!has_s) begin
         en = (prv == CFI_PRV_M) ? mlpe : menv;
      end else if (prv == CFI_PRV_M) begin
         en = mlpe;
      end else if (prv == CFI_PRV_S) begin
         en = virt ? henv : menv;
      end else begin
         en = senv;
      end
      return en;
   endfunction
endpackage

// ==== cfi_mode_enable.sv ====
// Per-privilege pad-check and shadow-stack enable resolver
`timescale 1ns/1ps
module cfi_mode_enable #(
   parameter bit HAS_SMODE = 1'b1
) (
   input wire logic [1:0] prv,
   input wire logic virt,
   input wire logic msec_mlpe,
   input wire logic menv_lpe,
   input wire logic henv_lpe,
   input wire logic senv_lpe,
   input wire logic menv_sse,
   input wire logic henv_sse,
   input wire logic senv_sse,
   output logic lpe,
   output logic shadow_stack_enable_field
);
   import cfi_pkg::*;

   always_comb begin
      lpe = cfi_lpe_of(prv, virt, HAS_SMODE, msec_mlpe, menv_lpe, henv_lpe, senv_lpe);
      shadow_stack_enable_field = 1'b0;
      if (HAS_SMODE && prv == CFI_PRV_S) begin
         shadow_stack_enable_field = virt ? henv_sse : menv_sse;
      end else if (HAS_SMODE && prv == CFI_PRV_U) begin
         shadow_stack_enable_field = senv_sse;
      end
   end
endmodule

// ==== cfi_ssp_gate.sv ====
// Ordered access checks for the shadow-stack pointer CSR
`timescale 1ns/1ps
module cfi_ssp_gate (
   input wire logic [1:0] prv,
   input wire logic virt,
   input wire logic menv_sse,
   input wire logic henv_sse,
   input wire logic senv_sse,
   output logic illegal,
   output logic virt_instr
);
   import cfi_pkg::*;

   always_comb begin
      illegal = 1'b0;
      virt_instr = 1'b0;
      if (prv != CFI_PRV_M && !menv_sse) begin
         illegal = 1'b1;
      end else if (prv == CFI_PRV_U && !virt && !senv_sse) begin
         illegal = 1'b1;
      end else if (prv == CFI_PRV_S && virt && !henv_sse) begin
         virt_instr = 1'b1;
      end else if (prv == CFI_PRV_U && virt && (!henv_sse || !senv_sse)) begin
         virt_instr = 1'b1;
      end
   end
endmodule

// ==== cfi_core_model.sv ====
// Core-side partner: trap sequencing and the machine handler's save and restore
`timescale 1ns/1ps
module cfi_core_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic auto_trap,
   input wire logic req_trap,
   input wire cfi_pkg::cfi_tgt_t req_tgt,
   input wire logic req_restore,
   input wire logic exc_valid_ff,
   input wire logic machine_prev_pad_state_ff,
   input wire logic super_prev_pad_state_ff,
   output logic trap_take,
   output cfi_pkg::cfi_tgt_t trap_tgt,
   output logic mst_wr_en,
   output logic mst_wr_mpad,
   output logic mst_wr_spad
);
   import cfi_pkg::*;
   logic took_ff;
   logic saved_pad_ff;
   // Faults are taken off the registered exc_valid_ff, so a required pad clears on the next op's first edge
   assign trap_take = req_trap | (auto_trap & exc_valid_ff);
   assign trap_tgt = req_trap ? req_tgt : CFI_TGT_M;
   // Only the saved bit is modelled; the x7 copy lives in software
   assign mst_wr_en = req_restore;
   assign mst_wr_mpad = saved_pad_ff;
   assign mst_wr_spad = super_prev_pad_state_ff;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         took_ff <= 1'b0;
         saved_pad_ff <= 1'b0;
      end else begin
         took_ff <= trap_take;
         if (took_ff) begin
            saved_pad_ff <= machine_prev_pad_state_ff;
         end
      end
   end
endmodule

// ==== cfi_trap_state_control_test.sv ====
// Self-checking bench for the CFI trap state block
`timescale 1ns/1ps
module cfi_trap_state_control_test;
   import cfi_pkg::*;
   logic clk_sys, nrst, cur_virt, ret_virt, dbg_virt, nmi_virt;
   logic [1:0] cur_prv, ret_prv, dbg_prv, nmi_prv;
   logic msec_mlpe, menv_lpe, henv_lpe, senv_lpe, menv_sse, henv_sse, senv_sse;
   logic ind_jump_retire, instr_valid, instr_is_pad, fetch_access_fault, illegal_instr;
   logic ssp_csr_access, ss_instr_valid, trap_take, mret_exec, sret_exec, dbg_enter;
   logic dbg_resume, nmi_take, nmi_return, mst_wr_en, mst_wr_mpad, mst_wr_spad;
   logic sst_wr_en, sst_wr_spad, vsst_wr_en, vsst_wr_spad, dcsr_wr_en, dcsr_wr_pad;
   logic nmist_wr_en, nmist_wr_pad, req_trap, req_restore;
   logic expected_landing_pad_state_ff, machine_prev_pad_state_ff, super_prev_pad_state_ff;
   logic vs_super_prev_pad_state_ff, dbg_prev_pad_state_ff, mode_pad_check_enable_ff;
   logic mode_shadow_stack_enable_ff, ss_as_mop_ff, ssp_access_ok_ff, exc_valid_ff;
   logic [CFI_NMIST_W-1:0] nmi_status_ff;
   logic [CFI_TVAL_W-1:0] exc_tval_ff;
   cfi_tgt_t trap_tgt, req_tgt;
   cfi_exc_t exc_kind_ff;
   int n_errors = 0;
   int samples_checked = 0;
   cfi_trap_state_control #(.HAS_SMODE(1'b1), .HAS_RESUMABLE_NMI(1'b1)) dut (
      .clk_sys, .nrst, .cur_prv, .cur_virt, .msec_mlpe, .menv_lpe, .henv_lpe, .senv_lpe,
      .menv_sse, .henv_sse, .senv_sse, .ind_jump_retire, .instr_valid, .instr_is_pad,
      .fetch_access_fault, .illegal_instr, .ssp_csr_access, .ss_instr_valid, .trap_take,
      .trap_tgt, .mret_exec, .sret_exec, .ret_prv, .ret_virt, .dbg_enter, .dbg_resume,
      .dbg_prv, .dbg_virt, .nmi_take, .nmi_return, .nmi_prv, .nmi_virt, .mst_wr_en,
      .mst_wr_mpad, .mst_wr_spad, .sst_wr_en, .sst_wr_spad, .vsst_wr_en, .vsst_wr_spad,
      .dcsr_wr_en, .dcsr_wr_pad, .nmist_wr_en, .nmist_wr_pad, .expected_landing_pad_state_ff,
      .machine_prev_pad_state_ff, .super_prev_pad_state_ff, .vs_super_prev_pad_state_ff,
      .dbg_prev_pad_state_ff, .nmi_status_ff, .mode_pad_check_enable_ff,
      .mode_shadow_stack_enable_ff, .ss_as_mop_ff, .ssp_access_ok_ff, .exc_valid_ff,
      .exc_kind_ff, .exc_tval_ff);
   cfi_core_model core (.clk_sys, .nrst, .auto_trap(1'b1), .req_trap, .req_tgt, .req_restore,
      .exc_valid_ff, .machine_prev_pad_state_ff, .super_prev_pad_state_ff, .trap_take,
      .trap_tgt, .mst_wr_en, .mst_wr_mpad, .mst_wr_spad);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic final_report;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #(25 * 5000);
      n_errors++;
      final_report();
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic clr;
      {ind_jump_retire, instr_valid, instr_is_pad, fetch_access_fault, illegal_instr,
       ssp_csr_access, ss_instr_valid, mret_exec, sret_exec, dbg_enter, dbg_resume, nmi_take,
       nmi_return, sst_wr_en, vsst_wr_en, dcsr_wr_en, nmist_wr_en, req_trap, req_restore} <= '0;
   endtask
   task automatic begin_op;
      @(posedge clk_sys);
   endtask
   // Strobes stand one edge; results are read once that edge has landed
   task automatic end_op;
      @(posedge clk_sys);
      clr();
      #1;
   endtask
   task automatic set_elp;
      begin_op();
      ind_jump_retire <= 1'b1;
      end_op();
   endtask
   task automatic trap(input cfi_tgt_t t);
      begin_op();
      req_trap <= 1'b1;
      req_tgt <= t;
      end_op();
   endtask
   task automatic mret(input logic [1:0] p);
      begin_op();
      mret_exec <= 1'b1;
      ret_prv <= p;
      end_op();
   endtask
   task automatic fault_case(input logic fa, input logic il, input logic pad, input cfi_exc_t k);
      set_elp();
      begin_op();
      instr_valid <= 1'b1;
      fetch_access_fault <= fa;
      illegal_instr <= il;
      instr_is_pad <= pad;
      end_op();
      chk("exc_valid", k != CFI_EXC_NONE, exc_valid_ff);
      chk("exc_kind", k, exc_valid_ff ? exc_kind_ff : CFI_EXC_NONE);
   endtask
   function automatic cfi_exc_t ssp_exp(input logic [1:0] p, input logic [3:0] v);
      if (p != CFI_PRV_M && !v[2]) return CFI_EXC_ILLEGAL;
      if (p == CFI_PRV_U && !v[3] && !v[0]) return CFI_EXC_ILLEGAL;
      if (p == CFI_PRV_S && v[3] && !v[1]) return CFI_EXC_VIRT_INSTR;
      if (p == CFI_PRV_U && v[3] && !(v[1] && v[0])) return CFI_EXC_VIRT_INSTR;
      return CFI_EXC_NONE;
   endfunction
   task automatic ssp_case(input logic [5:0] c);
      cfi_exc_t k;
      logic s;
      k = ssp_exp(c[5:4], c[3:0]);
      s = (c[5:4] == CFI_PRV_M) ? 1'b0 : (c[5:4] == CFI_PRV_U) ? c[0] : (c[3] ? c[1] : c[2]);
      begin_op();
      cur_prv <= c[5:4];
      cur_virt <= c[3];
      {menv_sse, henv_sse, senv_sse} <= c[2:0];
      {menv_lpe, henv_lpe, senv_lpe} <= c[2:0];
      begin_op();
      ssp_csr_access <= 1'b1;
      ss_instr_valid <= 1'b1;
      end_op();
      chk("ssp_ok", k == CFI_EXC_NONE, ssp_access_ok_ff);
      chk("ssp_exc", k, exc_valid_ff ? exc_kind_ff : CFI_EXC_NONE);
      chk("sse", s, mode_shadow_stack_enable_ff);
      chk("lpe", (c[5:4] == CFI_PRV_M) | s, mode_pad_check_enable_ff);
      chk("mop", !s, ss_as_mop_ff);
   endtask
   initial begin
      {nrst, cur_virt, ret_virt, dbg_virt, nmi_virt, menv_lpe, henv_lpe, senv_lpe} = '0;
      {menv_sse, henv_sse, senv_sse, sst_wr_spad, vsst_wr_spad, dcsr_wr_pad, nmist_wr_pad} = '0;
      {cur_prv, ret_prv, dbg_prv, nmi_prv} = {4{CFI_PRV_M}};
      msec_mlpe = 1'b1;
      req_tgt = CFI_TGT_M;
      clr();
      repeat (12) @(posedge clk_sys);
      #1;
      chk("rst_state", 32'h0, {expected_landing_pad_state_ff, machine_prev_pad_state_ff});
      chk("rst_nmi", 32'h0, nmi_status_ff);
      chk("rst_exc", 32'h0, exc_valid_ff);
      @(posedge clk_sys);
      nrst <= 1'b1;
      set_elp();
      trap(CFI_TGT_M);
      chk("mprev", 1'b1, machine_prev_pad_state_ff);
      chk("elp", 1'b0, expected_landing_pad_state_ff);
      mret(CFI_PRV_M);
      chk("elp", 1'b1, expected_landing_pad_state_ff);
      chk("mprev", 1'b0, machine_prev_pad_state_ff);
      $display("test trap and return done");
      fault_case(1'b0, 1'b0, 1'b0, CFI_EXC_SW_CHECK);
      chk("tval", 32'h0000_0002, exc_tval_ff);
      @(posedge clk_sys);
      #1;
      chk("mprev", 1'b1, machine_prev_pad_state_ff);
      chk("elp", 1'b0, expected_landing_pad_state_ff);
      begin_op();
      req_restore <= 1'b1;
      end_op();
      mret(CFI_PRV_M);
      chk("elp", 1'b1, expected_landing_pad_state_ff);
      trap(CFI_TGT_M);
      mret(CFI_PRV_U);
      chk("elp", 1'b0, expected_landing_pad_state_ff);
      chk("mprev", 1'b0, machine_prev_pad_state_ff);
      fault_case(1'b1, 1'b0, 1'b0, CFI_EXC_FETCH_ACCESS);
      fault_case(1'b0, 1'b1, 1'b0, CFI_EXC_SW_CHECK);
      fault_case(1'b0, 1'b0, 1'b1, CFI_EXC_NONE);
      chk("elp", 1'b0, expected_landing_pad_state_ff);
      $display("test pad fault done");
      set_elp();
      trap(CFI_TGT_HS);
      chk("sprev", 1'b1, super_prev_pad_state_ff);
      begin_op();
      sst_wr_en <= 1'b1;
      end_op();
      chk("sprev", 1'b0, super_prev_pad_state_ff);
      set_elp();
      trap(CFI_TGT_VS);
      chk("vsprev", 1'b1, vs_super_prev_pad_state_ff);
      chk("sprev", 1'b0, super_prev_pad_state_ff);
      // Guest return: saved guest bit restored through the hypervisor enable
      begin_op();
      sret_exec <= 1'b1;
      cur_virt <= 1'b1;
      ret_prv <= CFI_PRV_S;
      ret_virt <= 1'b1;
      henv_lpe <= 1'b1;
      end_op();
      chk("elp", 1'b1, expected_landing_pad_state_ff);
      chk("vsprev", 1'b0, vs_super_prev_pad_state_ff);
      $display("test supervisor save done");
      set_elp();
      begin_op();
      nmi_take <= 1'b1;
      end_op();
      chk("nmi_status", 16'h0200, nmi_status_ff);
      chk("elp", 1'b0, expected_landing_pad_state_ff);
      begin_op();
      nmi_return <= 1'b1;
      end_op();
      chk("elp", 1'b1, expected_landing_pad_state_ff);
      begin_op();
      nmist_wr_en <= 1'b1;
      end_op();
      chk("nmi_status", 16'h0000, nmi_status_ff);
      for (int r = 0; r < 2; r++) begin
         begin_op();
         dbg_enter <= 1'b1;
         end_op();
         chk("dprev", 1'b1, dbg_prev_pad_state_ff);
         chk("elp", 1'b0, expected_landing_pad_state_ff);
         begin_op();
         dbg_resume <= 1'b1;
         dbg_prv <= r[0] ? CFI_PRV_U : CFI_PRV_M;
         end_op();
         chk("elp", !r[0], expected_landing_pad_state_ff);
      end
      begin_op();
      dcsr_wr_en <= 1'b1;
      vsst_wr_en <= 1'b1;
      vsst_wr_spad <= 1'b1;
      end_op();
      chk("dprev", 1'b0, dbg_prev_pad_state_ff);
      chk("vsprev", 1'b1, vs_super_prev_pad_state_ff);
      $display("test debug and nmi done");
      for (int i = 0; i < 64; i++) begin
         if (i[5:4] != 2'h2 && !(i[5:4] == CFI_PRV_M && i[3])) begin
            ssp_case(i[5:0]);
         end
      end
      $display("test shadow stack done");
      final_report();
   end
endmodule
